// File: verilog/bdsr_pkg.sv
// package: register map, field layout and carriers for the bridge driver status registers
// Overview of operation
// RQ1 - reserved bits of both status registers always read as zero
// RQ2 - output-level bit follows high-side comparator when mode is 11 and pump enabled
// RQ3 - output-level bit forced low when pump disabled or mode differs from 11
// RQ4 - bits 3:0 of general status mirror the four pwm input levels
// RQ5 - both registers clear to zero on power-on or soft reset
// RQ6 - restart clears all bits except 7, 6 and 0
// RQ7 - regulation bit is one when turn-on or turn-off delay is regulated
// RQ8 - precharge bit zero when clamped under adaptive control, one when strictly between
// RQ9 - predischarge bit zero when clamped under adaptive control, one when strictly between
// RQ10 - clamp bits read one whenever adaptive control, pwm or bridge drive is off
// RQ11 - both registers read-only; writes ignored, reads have no side effect
package bdsr_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [6:0] BDSR_ADDR_GEN = 7'h50;
    localparam logic [6:0] BDSR_ADDR_DLY = 7'h51;
    localparam int BDSR_ADDR_W = 7;
    localparam int BDSR_DATA_W = 16;
    localparam int BDSR_NUM_HB = 4;
    localparam int BDSR_MODE_W = 2;
    localparam logic [15:0] BDSR_RESET_VAL = 16'h0000;
    // ****************************************
    // field layout
    // ****************************************
    localparam int BDSR_GEN_PWM_LSB = 0;
    localparam int BDSR_GEN_VOUT_LSB = 6;
    localparam int BDSR_DLY_REG_LSB = 0;
    localparam int BDSR_DLY_PCHG_LSB = 4;
    localparam int BDSR_DLY_PDCHG_LSB = 8;
    // bits that keep their value across a restart
    localparam logic [15:0] BDSR_RESTART_KEEP = 16'h00C1;
    // ****************************************
    // encodings
    // ****************************************
    localparam logic [1:0] BDSR_MODE_SENSE = 2'h3;
    localparam logic [1:0] BDSR_AGC_ADAPT_A = 2'h2;
    localparam logic [1:0] BDSR_AGC_ADAPT_B = 2'h3;

    typedef struct packed {
        logic [1:0] mode;
        logic hs_high;
        logic pwm_en;
        logic hi_z;
        logic pchg_between;
        logic pdchg_between;
        logic ton_reg;
        logic toff_reg;
    } bdsr_hb_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [6:0] addr;
    } bdsr_req_t;
endpackage

// File: verilog/bdsr_hb_slice.sv
// one half-bridge slice: derives its status bits from sensed levels and settings
`timescale 1ns/1ps
module bdsr_hb_slice (
    input wire bdsr_pkg::bdsr_hb_t hb_in,
    input wire logic cp_en_in,
    input wire logic [1:0] agc_in,
    output logic vout_out,
    output logic pchg_out,
    output logic pdchg_out,
    output logic reg_out
);
    logic adapt;
    always_comb begin
        adapt = (agc_in == bdsr_pkg::BDSR_AGC_ADAPT_A || agc_in == bdsr_pkg::BDSR_AGC_ADAPT_B)
            && hb_in.pwm_en && !hb_in.hi_z;
        vout_out = cp_en_in && (hb_in.mode == bdsr_pkg::BDSR_MODE_SENSE) && hb_in.hs_high; // RQ2 RQ3
        pchg_out = adapt ? hb_in.pchg_between : 1'b1; // RQ8 RQ10
        pdchg_out = adapt ? hb_in.pdchg_between : 1'b1; // RQ9 RQ10
        reg_out = hb_in.ton_reg || hb_in.toff_reg; // RQ7
    end
endmodule

// File: verilog/bdsr_top.sv
// top: bridge driver status register pair with read port
`timescale 1ns/1ps
module bdsr_top #(
    parameter int NUM_HB = bdsr_pkg::BDSR_NUM_HB
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic restart_in,
    input wire bdsr_pkg::bdsr_req_t req_in,
    input wire logic [NUM_HB-1:0] pwm_pin_in,
    input wire logic [NUM_HB-1:0] hs_high_pin_in,
    input wire logic cp_en_in,
    input wire logic [1:0] agc_in,
    input wire logic [2*NUM_HB-1:0] mode_in,
    input wire logic [NUM_HB-1:0] pwm_en_in,
    input wire logic [NUM_HB-1:0] hi_z_in,
    input wire logic [NUM_HB-1:0] pchg_between_in,
    input wire logic [NUM_HB-1:0] pdchg_between_in,
    input wire logic [NUM_HB-1:0] ton_reg_in,
    input wire logic [NUM_HB-1:0] toff_reg_in,
    output logic [15:0] rd_data_out,
    output logic rd_valid_out
);
    // ****************************************
    // pwm pin synchroniser
    // ****************************************
    // the pins are asynchronous, two flops before any logic reads them
    logic [NUM_HB-1:0] pwm_s1_q;
    logic [NUM_HB-1:0] pwm_s1_d;
    logic [NUM_HB-1:0] pwm_s2_q;
    logic [NUM_HB-1:0] pwm_s2_d;
    always_comb begin
        pwm_s1_d = pwm_pin_in;
        pwm_s2_d = pwm_s1_q;
    end
    // only the second flop feeds the status logic
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            pwm_s1_q <= '0;
            pwm_s2_q <= '0;
        end else if (clk_en_in) begin
            pwm_s1_q <= pwm_s1_d;
            pwm_s2_q <= pwm_s2_d;
        end
    end

    // ****************************************
    // high-side comparator synchroniser
    // ****************************************
    // comparator outputs are asynchronous as well
    logic [NUM_HB-1:0] hs_s1_q;
    logic [NUM_HB-1:0] hs_s1_d;
    logic [NUM_HB-1:0] hs_s2_q;
    logic [NUM_HB-1:0] hs_s2_d;
    always_comb begin
        hs_s1_d = hs_high_pin_in;
        hs_s2_d = hs_s1_q;
    end
    // only the second flop feeds the bridge slices
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            hs_s1_q <= '0;
            hs_s2_q <= '0;
        end else if (clk_en_in) begin
            hs_s1_q <= hs_s1_d;
            hs_s2_q <= hs_s2_d;
        end
    end

    // ****************************************
    // per-bridge status
    // ****************************************
    logic [NUM_HB-1:0] vout, pchg, pdchg, treg;
    for (genvar i = 0; i < NUM_HB; i++) begin : g_hb
        bdsr_pkg::bdsr_hb_t hb;
        always_comb begin
            // settings are same-clock levels and pass straight to the slice
            hb.mode = mode_in[bdsr_pkg::BDSR_MODE_W*i +: bdsr_pkg::BDSR_MODE_W];
            hb.hs_high = hs_s2_q[i];
            hb.pwm_en = pwm_en_in[i];
            hb.hi_z = hi_z_in[i];
            hb.pchg_between = pchg_between_in[i];
            hb.pdchg_between = pdchg_between_in[i];
            hb.ton_reg = ton_reg_in[i];
            hb.toff_reg = toff_reg_in[i];
        end
        bdsr_hb_slice u_slice (
            .hb_in(hb),
            .cp_en_in(cp_en_in),
            .agc_in(agc_in),
            .vout_out(vout[i]),
            .pchg_out(pchg[i]),
            .pdchg_out(pdchg[i]),
            .reg_out(treg[i])
        );
    end

    // ****************************************
    // general status register
    // ****************************************
    // live view of the pins and comparators, reserved bits tied low
    logic [15:0] gen_live;
    logic [NUM_HB-1:0] gen_pwm_field;
    logic [NUM_HB-1:0] gen_vout_field;
    always_comb begin
        gen_pwm_field = pwm_s2_q; // RQ4
        gen_vout_field = vout; // RQ2 RQ3
        gen_live = '0; // RQ1
        gen_live[bdsr_pkg::BDSR_GEN_PWM_LSB +: NUM_HB] = gen_pwm_field; // RQ4
        gen_live[bdsr_pkg::BDSR_GEN_VOUT_LSB +: NUM_HB] = gen_vout_field; // RQ2
    end

    // next value: restart clears all but bits 7, 6 and 0, which hold
    logic [15:0] gen_q;
    logic [15:0] gen_d;
    always_comb begin
        if (restart_in) begin
            gen_d = gen_q & bdsr_pkg::BDSR_RESTART_KEEP; // RQ6
        end else begin
            gen_d = gen_live;
        end
    end
    // register: frozen while the clock enable is low
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            gen_q <= bdsr_pkg::BDSR_RESET_VAL; // RQ5
        end else if (clk_en_in) begin
            gen_q <= gen_d;
        end
    end

    // ****************************************
    // delay regulation status register
    // ****************************************
    // live view of the per-bridge regulation and clamp status
    logic [15:0] dly_live;
    logic [NUM_HB-1:0] dly_reg_field;
    logic [NUM_HB-1:0] dly_pchg_field;
    logic [NUM_HB-1:0] dly_pdchg_field;
    always_comb begin
        dly_reg_field = treg; // RQ7
        dly_pchg_field = pchg; // RQ8 RQ10
        dly_pdchg_field = pdchg; // RQ9 RQ10
        dly_live = '0; // RQ1
        dly_live[bdsr_pkg::BDSR_DLY_REG_LSB +: NUM_HB] = dly_reg_field; // RQ7
        dly_live[bdsr_pkg::BDSR_DLY_PCHG_LSB +: NUM_HB] = dly_pchg_field; // RQ8
        dly_live[bdsr_pkg::BDSR_DLY_PDCHG_LSB +: NUM_HB] = dly_pdchg_field; // RQ9
    end

    // next value: same restart rule as the general register
    logic [15:0] dly_q;
    logic [15:0] dly_d;
    always_comb begin
        if (restart_in) begin
            dly_d = dly_q & bdsr_pkg::BDSR_RESTART_KEEP; // RQ6
        end else begin
            dly_d = dly_live;
        end
    end
    // register: frozen while the clock enable is low
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            dly_q <= bdsr_pkg::BDSR_RESET_VAL; // RQ5
        end else if (clk_en_in) begin
            dly_q <= dly_d;
        end
    end

    // ****************************************
    // read address decode
    // ****************************************
    // only reads are decoded, a write never reaches the registers
    // reading has no side effect on either register
    logic rd_req;
    logic hit_gen;
    logic hit_dly;
    always_comb begin
        rd_req = req_in.rd; // RQ11
        hit_gen = 1'b0;
        hit_dly = 1'b0;
        if (rd_req && req_in.addr == bdsr_pkg::BDSR_ADDR_GEN) begin
            hit_gen = 1'b1;
        end else if (rd_req && req_in.addr == bdsr_pkg::BDSR_ADDR_DLY) begin
            hit_dly = 1'b1;
        end
    end

    // ****************************************
    // read data register
    // ****************************************
    // unmapped addresses answer zero so the host never sees stale data
    logic [15:0] rd_data_q;
    logic [15:0] rd_data_d;
    logic rd_valid_q;
    logic rd_valid_d;
    // valid pulses for one enabled cycle per read request
    always_comb begin
        rd_valid_d = rd_req;
        rd_data_d = '0;
        if (hit_gen) begin
            rd_data_d = gen_q;
        end else if (hit_dly) begin
            rd_data_d = dly_q;
        end
    end
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rd_data_q <= '0;
            rd_valid_q <= 1'b0;
        end else if (clk_en_in) begin
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // both outputs are plain flop outputs
    assign rd_data_out = rd_data_q;
    assign rd_valid_out = rd_valid_q;
endmodule

// File: bench/bdsr_top_properties.sv
// checker: read-port properties of the bridge driver status registers
`timescale 1ns/1ps
module bdsr_top_chk #(parameter int NUM_HB = 4) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic restart_in,
    input wire bdsr_pkg::bdsr_req_t req_in,
    input wire logic cp_en_in,
    input wire logic [1:0] agc_in,
    input wire logic [NUM_HB-1:0] pwm_pin_in,
    input wire logic [NUM_HB-1:0] ton_reg_in,
    input wire logic [NUM_HB-1:0] toff_reg_in,
    input wire logic [15:0] rd_data_out,
    input wire logic rd_valid_out
);
    logic g;
    logic d;
    assign g = clk_en_in && req_in.rd && req_in.addr == bdsr_pkg::BDSR_ADDR_GEN;
    assign d = clk_en_in && req_in.rd && req_in.addr == bdsr_pkg::BDSR_ADDR_DLY;
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    chk_gen_reserved_zero: assert property (g |=> rd_data_out[15:10] == 6'h00 &&
        rd_data_out[5:4] == 2'h0) else $error("general reserved bits set");
    chk_dly_reserved_zero: assert property (d |=> rd_data_out[15:12] == 4'h0)
        else $error("delay reserved bits set");
    chk_reset_clears_all: assert property ($fell(rst_in) |-> rd_data_out == 16'h0000 &&
        !rd_valid_out) else $error("outputs not clear after reset");
    chk_pump_off_low: assert property (g && $past(clk_en_in) && !$past(restart_in) &&
        !$past(cp_en_in) |=> rd_data_out[9:6] == 4'h0)
        else $error("output level set with pump off");
    chk_pwm_level_mirror: assert property (g && !$past(restart_in) && $past(clk_en_in) &&
        $past(clk_en_in, 2) && $past(clk_en_in, 3) |=>
        rd_data_out[3:0] == $past(pwm_pin_in, 4)) else $error("pwm level mismatch");
    chk_delay_reg_or: assert property (d && $past(clk_en_in) && !$past(restart_in) |=>
        rd_data_out[3:0] == $past(ton_reg_in | toff_reg_in, 2)) else $error("regulation bits");
    chk_clamp_off_one: assert property (d && $past(clk_en_in) && !$past(restart_in) &&
        !$past(agc_in[1]) |=> rd_data_out[11:4] == 8'hFF) else $error("clamp bits not one");
    chk_restart_clear: assert property ((g || d) && $past(clk_en_in) && $past(restart_in) |=>
        (rd_data_out & 16'hFF3E) == 16'h0000) else $error("restart left bits set");
endmodule
bind bdsr_top bdsr_top_chk #(.NUM_HB(NUM_HB)) bdsr_top_chk_i (.core_clk_in, .rst_in, .clk_en_in,
    .restart_in, .req_in, .cp_en_in, .agc_in, .pwm_pin_in, .ton_reg_in, .toff_reg_in,
    .rd_data_out, .rd_valid_out);

// File: bench/bdsr_host_model.sv
// host model: serial master issuing single register transfers
`timescale 1ns/1ps
module bdsr_host_model (
    input wire logic clk_in,
    input wire logic [15:0] rd_data_in,
    input wire logic rd_valid_in,
    output bdsr_pkg::bdsr_req_t req_out
);
    initial req_out = '0;
    // no answer returns a marker so a missing read shows up
    task automatic xfer(input logic [6:0] a, input logic w, output logic [15:0] q);
        @(posedge clk_in);
        req_out <= '{rd: ~w, wr: w, addr: a};
        @(posedge clk_in);
        req_out <= '0;
        @(negedge clk_in);
        q = rd_valid_in ? rd_data_in : 16'hDEAD;
    endtask
endmodule

// File: bench/test_bdsr_top.sv
// testbench: directed scenarios for the bridge driver status registers
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, a, e); end end
module test_bdsr_top;
    logic clk = 1'b0, rst = 1'b1, restart = 1'b0, cp_en = 1'b0, cen = 1'b1, rval;
    logic [1:0] adaptive_gate_control_sel = 2'h2;
    logic [7:0] mode = 8'h00;
    logic [3:0] pwm = 4'h0, hs = 4'h0, pen = 4'hF, hiz = 4'h0, pc = 4'h0, pd = 4'h0;
    logic [3:0] ton = 4'h0, toff = 4'h0;
    logic [15:0] rdat, d;
    bdsr_pkg::bdsr_req_t req;
    int errors = 0, compares = 0;
    bdsr_top bdsr_top_i (.core_clk_in(clk), .rst_in(rst), .clk_en_in(cen), .restart_in(restart),
        .req_in(req), .pwm_pin_in(pwm), .hs_high_pin_in(hs), .cp_en_in(cp_en), .agc_in(adaptive_gate_control_sel),
        .mode_in(mode), .pwm_en_in(pen), .hi_z_in(hiz), .pchg_between_in(pc),
        .pdchg_between_in(pd), .ton_reg_in(ton), .toff_reg_in(toff), .rd_data_out(rdat),
        .rd_valid_out(rval));
    bdsr_host_model bdsr_host_model_i (.clk_in(clk), .rd_data_in(rdat), .rd_valid_in(rval),
        .req_out(req));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic rd(input logic [6:0] a, input logic w, input logic [15:0] e);
        bdsr_host_model_i.xfer(a, w, d);
        `CHK(d, e)
    endtask
    task automatic settle;
        repeat (4) @(posedge clk);
    endtask
    task automatic t_reset;
        rd(7'h51, 1'b0, 16'h0000);
        rd(7'h50, 1'b0, 16'h0000);
        rd(7'h52, 1'b0, 16'h0000);
        rd(7'h51, 1'b1, 16'hDEAD);
        $display("reset test done");
    endtask
    task automatic t_vout;
        @(posedge clk) {cp_en, hs} <= 5'h1F;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) mode <= 8'h03 << (2 * i);
            settle();
            rd(7'h50, 1'b0, 16'h0040 << i);
        end
        @(posedge clk) {mode, hs} <= 12'hAA5;
        settle();
        rd(7'h50, 1'b0, 16'h0000);
        @(posedge clk) mode <= 8'hFF;
        settle();
        rd(7'h50, 1'b0, 16'h0140);
        @(posedge clk) cp_en <= 1'b0;
        settle();
        rd(7'h50, 1'b0, 16'h0000);
        $display("output level test done");
    endtask
    task automatic t_dly;
        @(posedge clk) {pc, pd, ton, toff} <= 16'h5A35;
        for (int a = 0; a < 4; a++) begin
            @(posedge clk) adaptive_gate_control_sel <= a[1:0];
            settle();
            rd(7'h51, 1'b0, a[1] ? 16'h0A57 : 16'h0FF7);
        end
        @(posedge clk) {hiz, pen} <= 8'h17;
        settle();
        rd(7'h51, 1'b0, 16'h0BD7);
        $display("delay regulation test done");
    endtask
    task automatic t_restart;
        @(posedge clk) {mode, cp_en, hs, pwm} <= 17'h1FFFA;
        settle();
        rd(7'h50, 1'b0, 16'h03CA);
        @(posedge clk) restart <= 1'b1;
        settle();
        rd(7'h50, 1'b0, 16'h00C0);
        rd(7'h51, 1'b0, 16'h00C1);
        rd(7'h50, 1'b1, 16'hDEAD);
        @(posedge clk) restart <= 1'b0;
        settle();
        rd(7'h50, 1'b0, 16'h03CA);
        $display("restart test done");
    endtask
    task automatic t_freeze;
        @(posedge clk) {cen, pwm} <= 5'h05;
        settle();
        rd(7'h50, 1'b0, 16'hDEAD);
        @(posedge clk) cen <= 1'b1;
        rd(7'h50, 1'b0, 16'h03CA);
        settle();
        rd(7'h50, 1'b0, 16'h03C5);
        $display("clock enable test done");
    endtask
    task automatic final_report;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_vout();
        t_dly();
        t_restart();
        t_freeze();
        final_report();
    end
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        final_report();
    end
endmodule
